/* File: design/pin_func_decode.sv */
`timescale 1ns/1ps
// Purpose: per-channel combinational function decode
// Assumes: inputs come from registers on the same clock
// Notes: identical decode for every channel
module pin_func_decode
  import pin_sel_pkg::*;
(
  // control
  input  wire logic            pwm_sel_i,
  input  wire logic [IO_W-1:0] io_field_i,
  input  wire logic            dir_i,
  // result
  output pin_sel_pkg::pin_func_t func_o
);
  always_comb begin
    if (pwm_sel_i) begin
      func_o = FUNC_PWM;
    end else if (!io_field_i[2] && (io_field_i[1:0] != 2'h0)) begin
      func_o = FUNC_COMPARE;
    end else if (!dir_i) begin
      func_o = FUNC_PORT_IN;
    end else begin
      func_o = FUNC_PORT_OUT;
    end
  end
endmodule

/* File: design/pin_sel_pkg.sv */
// Purpose: constants for the timer / port pin function select
// Assumes: one system clock, asynchronous active-low reset
// Notes: channel index 0 = B (pin 2), 1 = C (pin 3), 2 = D (pin 4)
package pin_sel_pkg;
  localparam int unsigned NUM_CHAN = 3;
  localparam int unsigned IO_W     = 3;
  localparam logic [1:0]  RST_FUNC = 2'h0;

  typedef enum logic [1:0] {
    FUNC_PORT_IN  = 2'b00,
    FUNC_PORT_OUT = 2'b01,
    FUNC_COMPARE  = 2'b10,
    FUNC_PWM      = 2'b11
  } pin_func_t;
endpackage

/* File: design/timer_w_port8_pin_function_select.sv */
`timescale 1ns/1ps
// Purpose: select function of three shared timer / port pins
// Assumes: control bits, port data and timer outputs are on clk_sys_i;
//          pin input level is asynchronous
// Notes: outputs registered, one cycle after the control change
module timer_w_port8_pin_function_select
  import pin_sel_pkg::*;
(
  // clock and reset
  input  wire logic                clk_sys_i,
  input  wire logic                arst_n_i,
  // control bits, index 0 = B, 1 = C, 2 = D
  input  wire logic [NUM_CHAN-1:0] pwm_select_i,
  input  wire logic [NUM_CHAN-1:0] io_field_bit0_i,
  input  wire logic [NUM_CHAN-1:0] io_field_bit1_i,
  input  wire logic [NUM_CHAN-1:0] io_field_bit2_i,
  input  wire logic [NUM_CHAN-1:0] port_direction_i,
  // internal sources
  input  wire logic [NUM_CHAN-1:0] port_data_i,
  input  wire logic [NUM_CHAN-1:0] compare_out_i,
  input  wire logic [NUM_CHAN-1:0] pwm_out_i,
  // pins
  input  wire logic [NUM_CHAN-1:0] timer_io_pin_i,
  output logic      [NUM_CHAN-1:0] timer_io_pin_o,
  output logic      [NUM_CHAN-1:0] timer_io_pin_oe_o,
  // to port and capture logic
  output logic      [NUM_CHAN-1:0] port_in_o,
  output logic      [NUM_CHAN-1:0] capture_in_o,
  output logic      [NUM_CHAN-1:0] capture_en_o
);
  import pin_sel_pkg::*;

  // ------------------------------------------------------------
  // input synchroniser
  // ------------------------------------------------------------
  logic [NUM_CHAN-1:0] sync1_r, sync2_r;
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= timer_io_pin_i;
      sync2_r <= sync1_r;
    end
  end

  // ------------------------------------------------------------
  // per-channel decode and output registers
  // ------------------------------------------------------------
  pin_func_t           func   [NUM_CHAN];
  pin_func_t           func_r [NUM_CHAN];
  logic [NUM_CHAN-1:0] pin_r, pin_nxt, oe_r, oe_nxt;
  logic [NUM_CHAN-1:0] cap_en_r, cap_en_nxt;
  logic [NUM_CHAN-1:0] port_in_r, cap_in_r;

  genvar g;
  generate
    for (g = 0; g < NUM_CHAN; g++) begin : g_chan
      pin_func_decode u_dec (
        .pwm_sel_i  (pwm_select_i[g]),
        .io_field_i ({io_field_bit2_i[g], io_field_bit1_i[g],
                      io_field_bit0_i[g]}),
        .dir_i      (port_direction_i[g]),
        .func_o     (func[g])
      );

      always_comb begin
        unique case (func[g])
          FUNC_PORT_IN: begin
            pin_nxt[g]    = 1'b0;
            oe_nxt[g]     = 1'b0;
            cap_en_nxt[g] = 1'b1;
          end
          FUNC_PORT_OUT: begin
            pin_nxt[g]    = port_data_i[g];
            oe_nxt[g]     = 1'b1;
            cap_en_nxt[g] = 1'b1;
          end
          FUNC_COMPARE: begin
            pin_nxt[g]    = compare_out_i[g];
            oe_nxt[g]     = 1'b1;
            cap_en_nxt[g] = 1'b0;
          end
          FUNC_PWM: begin
            pin_nxt[g]    = pwm_out_i[g];
            oe_nxt[g]     = 1'b1;
            cap_en_nxt[g] = 1'b0;
          end
        endcase
      end

      always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          func_r[g] <= pin_func_t'(RST_FUNC);
        end else begin
          func_r[g] <= func[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pin_r     <= '0;
      oe_r      <= '0;
      cap_en_r  <= '1;
      port_in_r <= '0;
      cap_in_r  <= '0;
    end else begin
      pin_r     <= pin_nxt;
      oe_r      <= oe_nxt;
      cap_en_r  <= cap_en_nxt;
      port_in_r <= sync2_r;
      cap_in_r  <= sync2_r & cap_en_nxt;
    end
  end

  assign timer_io_pin_o    = pin_r;
  assign timer_io_pin_oe_o = oe_r;
  assign port_in_o         = port_in_r;
  assign capture_in_o      = cap_in_r;
  assign capture_en_o      = cap_en_r;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);

  // ------------------------------------------------------------
  // channel d
  // ------------------------------------------------------------
  d_port_in_a: assert property (
    !pwm_select_i[2] && !port_direction_i[2] &&
    (io_field_bit2_i[2] || {io_field_bit1_i[2], io_field_bit0_i[2]} == 2'h0)
    |=> !timer_io_pin_oe_o[2] && capture_en_o[2])
    else $error("chan d not port input");
  d_port_out_a: assert property (
    !pwm_select_i[2] && port_direction_i[2] &&
    (io_field_bit2_i[2] || {io_field_bit1_i[2], io_field_bit0_i[2]} == 2'h0)
    |=> timer_io_pin_oe_o[2] && capture_en_o[2] &&
        timer_io_pin_o[2] == $past(port_data_i[2]))
    else $error("chan d not port output");
  d_compare_a: assert property (
    !pwm_select_i[2] && !io_field_bit2_i[2] &&
    (io_field_bit1_i[2] || io_field_bit0_i[2])
    |=> timer_io_pin_oe_o[2] &&
        timer_io_pin_o[2] == $past(compare_out_i[2]))
    else $error("chan d compare not selected");
  d_pwm_wins_a: assert property (
    pwm_select_i[2]
    |=> timer_io_pin_oe_o[2] && !capture_en_o[2] &&
        timer_io_pin_o[2] == $past(pwm_out_i[2]))
    else $error("chan d pwm not selected");

  // ------------------------------------------------------------
  // channel c
  // ------------------------------------------------------------
  c_port_in_a: assert property (
    !pwm_select_i[1] && !port_direction_i[1] &&
    (io_field_bit2_i[1] || {io_field_bit1_i[1], io_field_bit0_i[1]} == 2'h0)
    |=> !timer_io_pin_oe_o[1] && capture_en_o[1])
    else $error("chan c not port input");
  c_port_out_a: assert property (
    !pwm_select_i[1] && port_direction_i[1] &&
    (io_field_bit2_i[1] || {io_field_bit1_i[1], io_field_bit0_i[1]} == 2'h0)
    |=> timer_io_pin_oe_o[1] && capture_en_o[1] &&
        timer_io_pin_o[1] == $past(port_data_i[1]))
    else $error("chan c not port output");
  c_compare_a: assert property (
    !pwm_select_i[1] && !io_field_bit2_i[1] &&
    (io_field_bit1_i[1] || io_field_bit0_i[1])
    |=> timer_io_pin_oe_o[1] && !capture_en_o[1] &&
        timer_io_pin_o[1] == $past(compare_out_i[1]))
    else $error("chan c compare not selected");
  c_pwm_wins_a: assert property (
    pwm_select_i[1]
    |=> timer_io_pin_oe_o[1] &&
        timer_io_pin_o[1] == $past(pwm_out_i[1]))
    else $error("chan c pwm not selected");

  // ------------------------------------------------------------
  // channel b
  // ------------------------------------------------------------
  b_port_in_a: assert property (
    !pwm_select_i[0] && !port_direction_i[0] &&
    (io_field_bit2_i[0] || {io_field_bit1_i[0], io_field_bit0_i[0]} == 2'h0)
    |=> !timer_io_pin_oe_o[0] && capture_en_o[0])
    else $error("chan b not port input");
  b_port_out_a: assert property (
    !pwm_select_i[0] && port_direction_i[0] &&
    (io_field_bit2_i[0] || {io_field_bit1_i[0], io_field_bit0_i[0]} == 2'h0)
    |=> timer_io_pin_oe_o[0] && capture_en_o[0] &&
        timer_io_pin_o[0] == $past(port_data_i[0]))
    else $error("chan b not port output");
  b_compare_a: assert property (
    !pwm_select_i[0] && !io_field_bit2_i[0] &&
    (io_field_bit1_i[0] || io_field_bit0_i[0])
    |=> timer_io_pin_oe_o[0] && !capture_en_o[0] &&
        timer_io_pin_o[0] == $past(compare_out_i[0]))
    else $error("chan b compare not selected");
  b_pwm_wins_a: assert property (
    pwm_select_i[0]
    |=> timer_io_pin_oe_o[0] && !capture_en_o[0] &&
        timer_io_pin_o[0] == $past(pwm_out_i[0]))
    else $error("chan b pwm not selected");

  // ------------------------------------------------------------
  // input sync paths, checked once reset has left the flops
  // ------------------------------------------------------------
  cap_sync_a: assert property (
    $past(arst_n_i, 3) && $past(arst_n_i, 2) && $past(arst_n_i) &&
    capture_en_o[1] && capture_en_o[0]
    |-> capture_in_o[1:0] == $past(timer_io_pin_i[1:0], 3))
    else $error("capture path latency wrong");
  port_sync_a: assert property (
    $past(arst_n_i, 3) && $past(arst_n_i, 2) && $past(arst_n_i)
    |-> port_in_o == $past(timer_io_pin_i, 3))
    else $error("port input latency wrong");
  cap_gate_a: assert property (
    (capture_in_o & ~capture_en_o) == 3'h0)
    else $error("capture input not gated");

  // ------------------------------------------------------------
  // covers
  // ------------------------------------------------------------
  pwm_d_c: cover property (pwm_select_i[2] ##1 !pwm_select_i[2]);
  cmp_c_c: cover property (func_r[1] == FUNC_COMPARE);
  out_b_c: cover property (func_r[0] == FUNC_PORT_OUT ##1
                           func_r[0] == FUNC_PORT_IN);
  cap_b_c: cover property (capture_in_o[0] ##1 !capture_in_o[0]);
  in_d_c:  cover property (func_r[2] == FUNC_PORT_IN ##1
                           func_r[2] == FUNC_COMPARE);
endmodule

/* File: sim/board_model.sv */
`timescale 1ns/1ps
// Purpose: board side of the three shared pins
// Assumes: an undriven pin floats, modelled as a changing pattern
// Notes: wire level merges the design's drive with the board's
module board_model (
  // pins
  input  wire logic [2:0] pin_o_i,
  input  wire logic [2:0] oe_i,
  input  wire logic       clk_sys_i,
  output logic      [2:0] pin_i_o
);
  logic [2:0] ext_r;

  initial ext_r = 3'h5;
  // new random level each cycle; a floating bit may keep its level or flip
  always @(posedge clk_sys_i) begin
    ext_r <= #1 ~ext_r ^ 3'($urandom);
  end
  assign pin_i_o = (oe_i & pin_o_i) | (~oe_i & ext_r);
endmodule

/* File: sim/testbench.sv */
`timescale 1ns/1ps
// Purpose: sweep and random checks of the pin function select
// Assumes: drive, oe and capture enable one cycle after controls
// Notes: the driver queues notes, the monitor pops them
module testbench;
  import pin_sel_pkg::*;
  logic       clk_sys_i = 0;
  logic       arst_n_i  = 0;
  logic [2:0] pwm = 0, io0 = 0, io1 = 0, io2 = 0, dir = 0;
  logic [2:0] pdat = 0, cmp = 0, pwmo = 0;
  logic [2:0] pin_i, pin_o, oe, pin_in, cap_in, cap_en;
  logic [8:0] q[$];
  logic [8:0] exp_v, nxt;
  logic       have = 0;
  logic [8:0] hist = '0;
  int         mismatches = 0;
  int         n_tests = 0;
  int         cyc = 0;

  initial forever #10 clk_sys_i = ~clk_sys_i;

  timer_w_port8_pin_function_select uut (
    .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .pwm_select_i(pwm),
    .io_field_bit0_i(io0), .io_field_bit1_i(io1), .io_field_bit2_i(io2),
    .port_direction_i(dir), .port_data_i(pdat), .compare_out_i(cmp),
    .pwm_out_i(pwmo), .timer_io_pin_i(pin_i), .timer_io_pin_o(pin_o),
    .timer_io_pin_oe_o(oe), .port_in_o(pin_in), .capture_in_o(cap_in),
    .capture_en_o(cap_en));
  board_model brd (.pin_o_i(pin_o), .oe_i(oe), .clk_sys_i(clk_sys_i),
    .pin_i_o(pin_i));

  // bits: [8:6] capture enable, [5:3] drive when enabled, [2:0] oe
  function automatic logic [8:0] calc();
    logic [8:0] e;
    e = '0;
    for (int c = 0; c < 3; c++) begin
      if (pwm[c]) begin
        e[c]   = 1'b1;
        e[3+c] = pwmo[c];
      end else if (!io2[c] && (io1[c] || io0[c])) begin
        e[c]   = 1'b1;
        e[3+c] = cmp[c];
      end else begin
        e[c]   = dir[c];
        e[3+c] = pdat[c] & dir[c];
        e[6+c] = 1'b1;
      end
    end
    return e;
  endfunction

  task automatic chk(input int c, input logic [8:0] e);
    n_tests++;
    if ({e[6+c], e[3+c], e[c]} !== {cap_en[c], pin_o[c] & oe[c], oe[c]}) begin
      mismatches++;
      $display("FAIL func chan %0d exp %b got %b", c,
               {e[6+c], e[3+c], e[c]}, {cap_en[c], pin_o[c] & oe[c], oe[c]});
    end
  endtask

  // synced port level and gated capture level
  task automatic chk_in(input logic [2:0] e_port, input logic [2:0] e_cap);
    n_tests++;
    if ({e_port, e_cap} !== {pin_in, cap_in}) begin
      mismatches++;
      $display("FAIL pin sync exp %b got %b", {e_port, e_cap},
               {pin_in, cap_in});
    end
  endtask

  // pin levels as the design sampled them, cleared while in reset
  always @(posedge clk_sys_i) begin
    if (!arst_n_i) hist <= '0;
    else hist <= {hist[5:0], pin_i};
  end

  task automatic step(input logic [14:0] v);
    @(posedge clk_sys_i);
    #1;
    if (have) q.push_back(nxt);
    {pwm, io2, io1, io0, dir} = v;
    {pdat, cmp, pwmo} = 9'($urandom);
    nxt  = calc();
    have = 1'b1;
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(negedge clk_sys_i) begin
    if (q.size() > 0) begin
      exp_v = q.pop_front();
      chk(0, exp_v);
      chk(1, exp_v);
      chk(2, exp_v);
      chk_in(hist[8:6], hist[8:6] & exp_v[8:6]);
    end
  end

  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 2000) begin
      mismatches++;
      give_verdict();
    end
  end

  initial begin
    void'($urandom(32'h34b7f189));
    repeat (2) @(posedge clk_sys_i);
    #1;
    chk(0, 9'h1c0);
    chk(1, 9'h1c0);
    chk(2, 9'h1c0);
    chk_in(3'h0, 3'h0);
    $display("reset done");
    arst_n_i = 1'b1;
    for (int v = 0; v < 32; v++) begin
      step({{3{v[4]}}, {3{v[3]}}, {3{v[2]}}, {3{v[1]}}, {3{v[0]}}});
    end
    $display("sweep done");
    repeat (400) step(15'($urandom));
    step({pwm, io2, io1, io0, dir});
    repeat (2) @(negedge clk_sys_i);
    $display("random done");
    give_verdict();
  end
endmodule
